/* design/pin_func_pkg.sv */
`default_nettype none

package pin_func_pkg;

    // Clock rate and the power-up reset drive time.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned POR_TIME_MS = 100;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned POR_CYCLES = POR_TIME_MS * (CLK_HZ / MS_PER_S);

    // Receive FIFO shape and fill limit width.
    localparam int unsigned FIFO_WIDTH = 1;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned LIMIT_W = 4;

    // Interrupt sources, in priority order, index into the pending vector.
    localparam int unsigned SRC_COUNT = 7;
    localparam int unsigned SRC_TX_READY = 0;
    localparam int unsigned SRC_FIFO_FILL = 1;
    localparam int unsigned SRC_POR = 2;
    localparam int unsigned SRC_OVERRUN = 3;
    localparam int unsigned SRC_WAKE_TIMER = 4;
    localparam int unsigned SRC_EXT_INT = 5;
    localparam int unsigned SRC_LOW_SUPPLY = 6;

    // Status word layout: source code in the leading four bits, flags below.
    localparam int unsigned STATUS_W = 16;
    localparam int unsigned STATUS_CODE_W = 4;
    localparam int unsigned STATUS_FLAG_LSB = 5;
    localparam logic [STATUS_CODE_W-1:0] SRC_CODE_NONE = 4'h0;

    // Synchroniser lane assignment for the pins from outside.
    localparam int unsigned SYNC_W = 5;
    localparam int unsigned LANE_DATA = 0;
    localparam int unsigned LANE_RESET = 1;
    localparam int unsigned LANE_EXT = 2;
    localparam int unsigned LANE_CS = 3;
    localparam int unsigned LANE_SCK = 4;

    // Pin configuration settings from the configuration registers.
    typedef struct packed {
        logic digital_filter_sel;
        logic fifo_enable;
        logic [LIMIT_W-1:0] fifo_fill_limit;
        logic tx_reg_enable;
        logic valid_data_mode;
        logic receiver_on;
    } pin_cfg_s;

    // Interrupt events raised by other parts of the device.
    typedef struct packed {
        logic tx_ready;
        logic tx_underrun;
        logic wake_timer;
        logic low_supply;
    } dev_events_s;

    // Reset pin phases.
    typedef enum logic [0:0] {
        RST_DRIVE = 1'b0,
        RST_INPUT = 1'b1
    } rst_phase_e;

endpackage

`default_nettype wire

/* design/pin_sync.sv */
`default_nettype none

module pin_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // Only the second stage reads the first one.
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Two stages; reset to the pins' idle levels so no false edge is seen.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

`default_nettype wire

/* design/rx_fifo.sv */
`default_nettype none

module rx_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] level
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] wr_d;
    logic [AW-1:0] rd_q;
    logic [AW-1:0] rd_d;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    // Full and empty come straight from the count, so they never lie.
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;

    // Pointers wrap at DEPTH, which need not be a power of two.
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Storage carries no reset; only pointers and count need one.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

endmodule

`default_nettype wire

/* design/host_pin_functions.sv */
// Contract
// - Data pin low during a read selects FIFO; first bit on next serial clock.
// - Data pin pull-up is on while the transmit register is in use.
// - Without FIFO, received data leaves on the data pin with recovered clock.
// - Digital filter and FIFO off: multi-function pin carries recovered clock.
// - Digital filter and FIFO on: multi-function pin flags fill level reaching four-bit limit.
// - Analog filter: multi-function pin carries raw baseband data.
// - Reset pin driven low for 100 ms from power-up, then pulled-up active-low input.
// - External interrupt pin low asserts the host interrupt request.
// - Leading four status bits name the interrupt source.
// - External interrupt input also wakes the device from sleep.
// - Valid-data mode drives the shared pin from sync pattern recognition.
// - Interrupt request goes low for the seven listed device events.
`default_nettype none

module host_pin_functions
    import pin_func_pkg::*;
#(
    parameter int unsigned POR_HOLD_CYCLES = pin_func_pkg::POR_CYCLES,
    parameter int unsigned DEPTH = pin_func_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire pin_func_pkg::pin_cfg_s cfg,
    input wire pin_func_pkg::dev_events_s dev_events,
    input wire logic rx_bit,
    input wire logic rx_bit_strobe,
    input wire logic recovered_clock,
    input wire logic raw_baseband,
    input wire logic sync_pattern_hit,
    input wire logic sleep_active,
    input wire logic status_read,
    input wire logic data_fifo_select_pin_i,
    output logic data_fifo_select_pin_o,
    output logic data_fifo_select_pin_oe,
    output logic data_fifo_select_pullup_en,
    output logic clock_fifoint_filter_pin_o,
    input wire logic power_up_reset_pin_i,
    output logic power_up_reset_pin_o,
    output logic power_up_reset_pin_oe,
    output logic power_up_reset_pullup_en,
    input wire logic ext_interrupt_valid_pin_i,
    output logic ext_interrupt_valid_pin_o,
    output logic ext_interrupt_valid_pin_oe,
    input wire logic serial_chip_select_n,
    input wire logic serial_clock,
    output logic serial_data_out,
    output logic host_interrupt_request_n,
    output logic [pin_func_pkg::STATUS_W-1:0] status_word,
    output logic tx_modulation_bit,
    output logic device_reset,
    output logic wake_up,
    output logic fifo_write_ready,
    output logic [$clog2(DEPTH):0] fifo_level
);
    import pin_func_pkg::*;

    localparam int unsigned CW = $clog2(POR_HOLD_CYCLES + 1);
    localparam int unsigned LW = $clog2(DEPTH) + 1;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h0F;

    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_s;
    logic sck_prev_q;
    logic sck_rise;
    logic fifo_sel;
    logic fifo_out_valid;
    logic fifo_out_data;
    logic fifo_pop;
    logic fifo_push;
    logic fifo_overrun;
    logic fill_hit;
    logic ext_low;
    logic ext_fall;

    // Every pin from outside, and the serial clock, passes two flops first.
    assign pin_raw[LANE_DATA] = data_fifo_select_pin_i;
    assign pin_raw[LANE_RESET] = power_up_reset_pin_i;
    assign pin_raw[LANE_EXT] = ext_interrupt_valid_pin_i;
    assign pin_raw[LANE_CS] = serial_chip_select_n;
    assign pin_raw[LANE_SCK] = serial_clock;

    pin_sync #(
        .WIDTH(SYNC_W),
        .INIT(SYNC_IDLE)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    // The serial clock is slow against clk, so its edges are found by sampling.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= pin_s[LANE_SCK];
        end
    end

    assign sck_rise = pin_s[LANE_SCK] && !sck_prev_q;

    // FIFO read needs FIFO enabled, chip select low and the data pin held low.
    assign fifo_sel = cfg.fifo_enable && !pin_s[LANE_CS] && !pin_s[LANE_DATA];
    assign fifo_pop = fifo_sel && sck_rise && fifo_out_valid;
    assign fifo_push = cfg.fifo_enable && cfg.receiver_on && rx_bit_strobe;

    // A bit arriving at a full FIFO is dropped; the overrun flag reports it.
    rx_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_push),
        .in_ready(fifo_write_ready),
        .in_data(rx_bit),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    assign fifo_overrun = fifo_push && !fifo_write_ready;
    assign fill_hit = cfg.fifo_enable && (fifo_level >= LW'(cfg.fifo_fill_limit));

    // Power-up reset pin: drive low for the hold time, then become an input.
    rst_phase_e rst_phase_q;
    rst_phase_e rst_phase_d;
    logic [CW-1:0] por_cnt_q;
    logic [CW-1:0] por_cnt_d;
    logic por_done_q;
    logic por_done_d;
    logic dev_reset_q;
    logic dev_reset_d;

    always_comb begin
        rst_phase_d = rst_phase_q;
        por_cnt_d = por_cnt_q;
        por_done_d = 1'b0;
        dev_reset_d = 1'b0;
        unique case (rst_phase_q)
            RST_DRIVE: begin
                por_cnt_d = por_cnt_q + 1'b1;
                if (por_cnt_q == CW'(POR_HOLD_CYCLES - 1)) begin
                    rst_phase_d = RST_INPUT;
                    por_done_d = 1'b1;
                end
            end
            RST_INPUT: begin
                dev_reset_d = !pin_s[LANE_RESET];
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_phase_q <= RST_DRIVE;
            por_cnt_q <= '0;
            por_done_q <= 1'b0;
            dev_reset_q <= 1'b0;
        end else begin
            rst_phase_q <= rst_phase_d;
            por_cnt_q <= por_cnt_d;
            por_done_q <= por_done_d;
            dev_reset_q <= dev_reset_d;
        end
    end

    // The pull-up is only enabled once the pin stops being driven.
    assign power_up_reset_pin_o = 1'b0;
    assign power_up_reset_pin_oe = (rst_phase_q == RST_DRIVE);
    assign power_up_reset_pullup_en = (rst_phase_q == RST_INPUT);
    assign device_reset = dev_reset_q;

    // External interrupt: a falling level in interrupt mode is one event.
    logic ext_prev_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_low;
        end
    end

    assign ext_low = !cfg.valid_data_mode && !pin_s[LANE_EXT];
    assign ext_fall = ext_low && !ext_prev_q;

    // Pin outputs, registered; all but the serial output and modulation bit are recomputed each cycle.
    logic d_pin_o_q;
    logic d_pin_o_d;
    logic d_pin_oe_q;
    logic d_pin_oe_d;
    logic mf_pin_q;
    logic mf_pin_d;
    logic ev_pin_o_q;
    logic ev_pin_o_d;
    logic sdo_q;
    logic sdo_d;
    logic tx_mod_q;
    logic tx_mod_d;
    logic wake_q;
    logic wake_d;

    always_comb begin
        // Received data goes out on the data pin only when the FIFO is bypassed.
        d_pin_oe_d = cfg.receiver_on && !cfg.fifo_enable && !cfg.tx_reg_enable;
        d_pin_o_d = rx_bit;
        // Multi-function pin: analog filter wins, then FIFO flag, then clock.
        if (!cfg.digital_filter_sel) begin
            mf_pin_d = raw_baseband;
        end else if (cfg.fifo_enable) begin
            mf_pin_d = fill_hit;
        end else begin
            mf_pin_d = recovered_clock;
        end
        ev_pin_o_d = sync_pattern_hit;
        // The serial output holds its bit until the next selected clock edge, and drops to zero while the FIFO is not selected.
        sdo_d = sdo_q;
        if (fifo_pop) begin
            sdo_d = fifo_out_data;
        end else if (!fifo_sel) begin
            sdo_d = 1'b0;
        end
        // Host modulation is taken from the pin only while the pin is an input.
        tx_mod_d = tx_mod_q;
        if (!cfg.tx_reg_enable && !d_pin_oe_q) begin
            tx_mod_d = pin_s[LANE_DATA];
        end
        wake_d = sleep_active && ext_fall;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            d_pin_o_q <= 1'b0;
            d_pin_oe_q <= 1'b0;
            mf_pin_q <= 1'b0;
            ev_pin_o_q <= 1'b0;
            sdo_q <= 1'b0;
            tx_mod_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            d_pin_o_q <= d_pin_o_d;
            d_pin_oe_q <= d_pin_oe_d;
            mf_pin_q <= mf_pin_d;
            ev_pin_o_q <= ev_pin_o_d;
            sdo_q <= sdo_d;
            tx_mod_q <= tx_mod_d;
            wake_q <= wake_d;
        end
    end

    assign data_fifo_select_pin_o = d_pin_o_q;
    assign data_fifo_select_pin_oe = d_pin_oe_q;
    assign data_fifo_select_pullup_en = cfg.tx_reg_enable;
    assign clock_fifoint_filter_pin_o = mf_pin_q;
    assign ext_interrupt_valid_pin_o = ev_pin_o_q;
    assign ext_interrupt_valid_pin_oe = cfg.valid_data_mode;
    assign serial_data_out = sdo_q;
    assign tx_modulation_bit = tx_mod_q;
    assign wake_up = wake_q;

    // Interrupt sources: sticky until a status read, and a new event wins the clear.
    logic fill_prev_q;
    logic [SRC_COUNT-1:0] ev_now;
    logic [SRC_COUNT-1:0] pend_q;
    logic [SRC_COUNT-1:0] pend_d;
    logic [STATUS_W-1:0] status_q;
    logic [STATUS_W-1:0] status_d;
    logic [STATUS_CODE_W-1:0] src_code;

    always_comb begin
        ev_now = '0;
        ev_now[SRC_TX_READY] = dev_events.tx_ready;
        ev_now[SRC_FIFO_FILL] = fill_hit && !fill_prev_q;
        ev_now[SRC_POR] = por_done_q;
        ev_now[SRC_OVERRUN] = fifo_overrun || dev_events.tx_underrun;
        ev_now[SRC_WAKE_TIMER] = dev_events.wake_timer;
        ev_now[SRC_EXT_INT] = ext_fall;
        ev_now[SRC_LOW_SUPPLY] = dev_events.low_supply;
        pend_d = (status_read ? '0 : pend_q) | ev_now;
        // Lowest index pending names the source; zero means nothing pending.
        src_code = SRC_CODE_NONE;
        for (int i = SRC_COUNT - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                src_code = STATUS_CODE_W'(i + 1);
            end
        end
        status_d = status_q;
        if (status_read) begin
            status_d = '0;
            status_d[STATUS_W-1 -: STATUS_CODE_W] = src_code;
            status_d[STATUS_FLAG_LSB +: SRC_COUNT] = pend_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fill_prev_q <= 1'b0;
            pend_q <= '0;
            status_q <= '0;
        end else begin
            fill_prev_q <= fill_hit;
            pend_q <= pend_d;
            status_q <= status_d;
        end
    end

    assign host_interrupt_request_n = !(|pend_q);
    assign status_word = status_q;

endmodule

`default_nettype wire

/* bench/host_pin_functions_props.sv */
`default_nettype none

module host_pin_functions_props
    import pin_func_pkg::*;
#(
    parameter int unsigned POR_HOLD_CYCLES = 20,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire pin_func_pkg::pin_cfg_s cfg,
    input wire pin_func_pkg::dev_events_s dev_events,
    input wire logic recovered_clock,
    input wire logic raw_baseband,
    input wire logic sync_pattern_hit,
    input wire logic sleep_active,
    input wire logic status_read,
    input wire logic data_fifo_select_pin_oe,
    input wire logic data_fifo_select_pullup_en,
    input wire logic clock_fifoint_filter_pin_o,
    input wire logic power_up_reset_pin_oe,
    input wire logic power_up_reset_pullup_en,
    input wire logic ext_interrupt_valid_pin_o,
    input wire logic ext_interrupt_valid_pin_oe,
    input wire logic host_interrupt_request_n,
    input wire logic [pin_func_pkg::STATUS_W-1:0] status_word,
    input wire logic wake_up,
    input wire logic [$clog2(DEPTH):0] fifo_level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic [31:0] por_q;
    logic [31:0] por_d;

    // Counts reset-pin drive cycles to catch an endless hold.
    always_comb begin
        por_d = power_up_reset_pin_oe ? por_q + 32'h1 : por_q;
    end
    always_ff @(posedge clk) begin
        por_q <= sys_rst ? 32'h0 : por_d;
    end

    // Registered outputs follow the settings of the cycle before; pull-up and valid-pin enable follow in the same cycle.
    a_pullup_follows: assert property (data_fifo_select_pullup_en == cfg.tx_reg_enable)
        else $error("pull-up wrong");
    a_data_driven: assert property (cfg.receiver_on && !cfg.fifo_enable && !cfg.tx_reg_enable
        |=> data_fifo_select_pin_oe) else $error("data pin not driven");
    a_raw_baseband: assert property (!cfg.digital_filter_sel
        |=> clock_fifoint_filter_pin_o == $past(raw_baseband)) else $error("raw data not on pin");
    a_clock_out: assert property (cfg.digital_filter_sel && !cfg.fifo_enable
        |=> clock_fifoint_filter_pin_o == $past(recovered_clock)) else $error("clock not on pin");
    a_fill_flag: assert property (cfg.digital_filter_sel && cfg.fifo_enable
        && fifo_level >= cfg.fifo_fill_limit |=> clock_fifoint_filter_pin_o)
        else $error("fill flag missing");
    a_por_release: assert property ($fell(power_up_reset_pin_oe)
        |-> power_up_reset_pullup_en && por_q >= POR_HOLD_CYCLES - 1)
        else $error("reset release wrong");
    a_por_length: assert property (por_q <= POR_HOLD_CYCLES + 2)
        else $error("reset held long");
    a_event_irq: assert property ((|dev_events) |=> !host_interrupt_request_n)
        else $error("event without irq");
    a_status_code: assert property (status_read
        |=> (status_word[15:12] == 4'h0) == $past(host_interrupt_request_n))
        else $error("status code wrong");
    a_valid_out: assert property (cfg.valid_data_mode |-> ext_interrupt_valid_pin_oe
        ##1 (ext_interrupt_valid_pin_o == $past(sync_pattern_hit)))
        else $error("valid pin wrong");
    a_wake_sleep: assert property (wake_up |-> $past(sleep_active))
        else $error("wake outside sleep");

    c_por_end: cover property ($fell(power_up_reset_pin_oe));
    c_status_busy: cover property (status_read && !host_interrupt_request_n);
    c_wake: cover property (wake_up);
endmodule

`default_nettype wire

/* bench/host_model.sv */
`default_nettype none

module host_model (
    input wire logic clk,
    input wire logic d_o,
    input wire logic d_oe,
    input wire logic d_pu,
    input wire logic r_o,
    input wire logic r_oe,
    input wire logic r_pu,
    input wire logic e_o,
    input wire logic e_oe,
    input wire logic sdo,
    output wire logic d_pin,
    output wire logic r_pin,
    output wire logic e_pin,
    output wire logic cs_n,
    output wire logic sck
);
    timeunit 1ns;
    timeprecision 100ps;
    logic float_q = 1'b0;
    logic d_en = 1'b1;
    logic d_val = 1'b1;
    logic rst_low = 1'b0;
    logic ext_low = 1'b0;
    logic cs_q = 1'b1;
    logic sck_q = 1'b0;

    // A floating line wanders, so a stale level never passes.
    always @(posedge clk) float_q <= ~float_q;

    // Device wins, then host, then pull-up.
    assign d_pin = d_oe ? d_o : d_en ? d_val : d_pu ? 1'b1 : float_q;
    assign r_pin = r_oe ? r_o : rst_low ? 1'b0 : r_pu ? 1'b1 : float_q;
    assign e_pin = e_oe ? e_o : ~ext_low;
    assign cs_n = cs_q;
    assign sck = sck_q;

    // Reads a FIFO frame; the link clock idles outside it.
    task automatic read_fifo(input int n, output logic [15:0] bits);
        cs_q = 1'b0;
        d_val = 1'b0;
        #250;
        for (int i = 0; i < n; i++) begin
            sck_q = 1'b1;
            #62.5;
            sck_q = 1'b0;
            #50;
            bits[i] = sdo;
            #12.5;
        end
        cs_q = 1'b1;
        d_val = 1'b1;
    endtask
endmodule

`default_nettype wire

/* bench/host_pin_functions_bench.sv */
`default_nettype none

module host_pin_functions_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pin_func_pkg::*;
    localparam int unsigned POR_N = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    pin_cfg_s cfg = '0;
    dev_events_s dev_events = '0;
    logic rx_bit = 1'b0;
    logic rx_bit_strobe = 1'b0;
    logic recovered_clock = 1'b0;
    logic raw_baseband = 1'b0;
    logic sync_pattern_hit = 1'b0;
    logic sleep_active = 1'b0;
    logic status_read = 1'b0;
    logic d_o, d_oe, data_fifo_select_pullup_en, clock_fifoint_filter_pin_o, r_o, r_oe;
    logic power_up_reset_pullup_en, e_o, e_oe, serial_data_out, host_interrupt_request_n;
    logic tx_modulation_bit, device_reset, wake_up, fifo_write_ready;
    logic [STATUS_W-1:0] status_word;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    wire logic d_pin, r_pin, e_pin, cs_n, sck;
    int err_count = 0;
    int checked = 0;
    logic [15:0] rd;
    logic [15:0] pat = 16'hC3A5;
    logic [3:0] codes [4] = '{4'h1, 4'h4, 4'h5, 4'h7};

    always #5 clk = ~clk;

    host_pin_functions #(.POR_HOLD_CYCLES(POR_N)) u_host_pin_functions (
        .clk, .sys_rst, .cfg, .dev_events, .rx_bit, .rx_bit_strobe, .recovered_clock,
        .raw_baseband, .sync_pattern_hit, .sleep_active, .status_read,
        .data_fifo_select_pin_i(d_pin), .data_fifo_select_pin_o(d_o),
        .data_fifo_select_pin_oe(d_oe), .data_fifo_select_pullup_en,
        .clock_fifoint_filter_pin_o, .power_up_reset_pin_i(r_pin), .power_up_reset_pin_o(r_o),
        .power_up_reset_pin_oe(r_oe), .power_up_reset_pullup_en,
        .ext_interrupt_valid_pin_i(e_pin), .ext_interrupt_valid_pin_o(e_o),
        .ext_interrupt_valid_pin_oe(e_oe), .serial_chip_select_n(cs_n), .serial_clock(sck),
        .serial_data_out, .host_interrupt_request_n, .status_word, .tx_modulation_bit,
        .device_reset, .wake_up, .fifo_write_ready, .fifo_level);

    host_model u_host_model (.clk, .d_o, .d_oe, .d_pu(data_fifo_select_pullup_en), .r_o,
        .r_oe, .r_pu(power_up_reset_pullup_en), .e_o, .e_oe, .sdo(serial_data_out), .d_pin,
        .r_pin, .e_pin, .cs_n, .sck);

    task automatic end_sim();
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Sample at the falling edge, clear of the launch.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // A status read clears pending flags.
    task automatic read_status(input logic [3:0] code);
        @(posedge clk);
        status_read <= 1'b1;
        @(posedge clk);
        status_read <= 1'b0;
        settle(1);
        chk_val("status_code", {12'h000, code}, {12'h000, status_word[15:12]});
        chk_bit("irq_cleared", 1'b1, host_interrupt_request_n);
    endtask

    task automatic push(input logic b);
        @(posedge clk);
        rx_bit <= b;
        rx_bit_strobe <= 1'b1;
        @(posedge clk);
        rx_bit_strobe <= 1'b0;
    endtask

    task automatic mux(input logic dig, input logic fen, input logic raw, input logic rc,
        input logic exp);
        @(posedge clk);
        cfg.digital_filter_sel <= dig;
        cfg.fifo_enable <= fen;
        raw_baseband <= raw;
        recovered_clock <= rc;
        settle(1);
        chk_bit("mf_pin", exp, clock_fifoint_filter_pin_o);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        settle(2);
        chk_bit("rst_oe_hold", 1'b1, r_oe);
        settle(POR_N);
        chk_bit("rst_oe_end", 1'b0, r_oe);
        chk_bit("rst_pullup", 1'b1, power_up_reset_pullup_en);
        read_status(4'h3);
        u_host_model.rst_low = 1'b1;
        settle(5);
        chk_bit("device_reset", 1'b1, device_reset);
        u_host_model.rst_low = 1'b0;
        settle(5);
        chk_bit("device_reset_off", 1'b0, device_reset);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            dev_events <= 4'h8 >> i;
            @(posedge clk);
            dev_events <= '0;
            settle(1);
            chk_bit("irq_event", 1'b0, host_interrupt_request_n);
            read_status(codes[i]);
        end
        @(posedge clk);
        cfg.fifo_fill_limit <= 4'h4;
        cfg.receiver_on <= 1'b1;
        mux(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        mux(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        mux(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        mux(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        mux(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) push(pat[i]);
        settle(1);
        chk_bit("fill_flag", 1'b1, clock_fifoint_filter_pin_o);
        read_status(4'h2);
        for (int i = 4; i < 16; i++) push(pat[i]);
        settle(1);
        chk_bit("fifo_ready", 1'b0, fifo_write_ready);
        chk_val("fifo_full", 16'h0010, 16'(fifo_level));
        push(1'b0);
        read_status(4'h4);
        u_host_model.read_fifo(16, rd);
        chk_val("fifo_bits", pat, rd);
        settle(2);
        chk_val("fifo_empty", 16'h0000, 16'(fifo_level));
        u_host_model.d_en = 1'b0;
        @(posedge clk);
        cfg.fifo_enable <= 1'b0;
        settle(2);
        chk_bit("data_pin_oe", 1'b1, d_oe);
        chk_bit("d_out", 1'b0, d_o);
        @(posedge clk);
        cfg.tx_reg_enable <= 1'b1;
        settle(2);
        chk_bit("pullup", 1'b1, data_fifo_select_pullup_en);
        chk_bit("data_pin_free", 1'b0, d_oe);
        chk_bit("data_pin_level", 1'b1, d_pin);
        u_host_model.d_val = 1'b0;
        u_host_model.d_en = 1'b1;
        @(posedge clk);
        cfg <= '0;
        settle(5);
        chk_bit("tx_mod_low", 1'b0, tx_modulation_bit);
        u_host_model.d_val = 1'b1;
        settle(5);
        chk_bit("tx_mod_high", 1'b1, tx_modulation_bit);
        @(posedge clk);
        sleep_active <= 1'b1;
        settle(1);
        u_host_model.ext_low = 1'b1;
        rd[0] = 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (wake_up === 1'b1) rd[0] = 1'b1;
        end
        chk_bit("wake_up", 1'b1, rd[0]);
        chk_bit("irq_ext", 1'b0, host_interrupt_request_n);
        read_status(4'h6);
        u_host_model.ext_low = 1'b0;
        @(posedge clk);
        sleep_active <= 1'b0;
        cfg.valid_data_mode <= 1'b1;
        sync_pattern_hit <= 1'b1;
        settle(2);
        chk_bit("valid_oe", 1'b1, e_oe);
        chk_bit("valid_high", 1'b1, e_pin);
        @(posedge clk);
        sync_pattern_hit <= 1'b0;
        settle(2);
        chk_bit("valid_low", 1'b0, e_pin);
        end_sim();
    end

    // A hang is cut off after 5000 cycles.
    initial begin
        #50000;
        err_count++;
        end_sim();
    end
endmodule

bind host_pin_functions host_pin_functions_props #(
    .POR_HOLD_CYCLES(POR_HOLD_CYCLES), .DEPTH(DEPTH)) u_host_pin_functions_props (
    .clk, .sys_rst, .cfg, .dev_events, .recovered_clock, .raw_baseband, .sync_pattern_hit,
    .sleep_active, .status_read, .data_fifo_select_pin_oe, .data_fifo_select_pullup_en,
    .clock_fifoint_filter_pin_o, .power_up_reset_pin_oe, .power_up_reset_pullup_en,
    .ext_interrupt_valid_pin_o, .ext_interrupt_valid_pin_oe, .host_interrupt_request_n,
    .status_word, .wake_up, .fifo_level);

`default_nettype wire
